// ===== hdl/ped_msg_pkg.sv
package ped_msg_pkg;
  // message headers, host to device
  localparam logic [15:0] HDR_STAT_QUERY = 16'h4753;
  localparam logic [15:0] HDR_POS_REQ1   = 16'h4750;
  localparam logic [15:0] HDR_POS_REQ2   = 16'h4754;
  localparam logic [15:0] HDR_PSETUP1    = 16'h4950;
  localparam logic [15:0] HDR_PSETUP2    = 16'h4954;
  localparam logic [15:0] HDR_TAB_ASSN1  = 16'h544d;
  localparam logic [15:0] HDR_TAB_ASSN2  = 16'h544e;
  localparam logic [15:0] HDR_IRQ_CTL    = 16'h494b;
  localparam logic [15:0] HDR_EXT_ENTER  = 16'h4958;
  localparam logic [15:0] HDR_EXT_SETUP  = 16'h4856;
  localparam logic [15:0] HDR_EXT_REQ    = 16'h4f54;
  // message headers, device to host
  localparam logic [15:0] HDR_STAT_REPLY = 16'h5254;
  localparam logic [15:0] HDR_POS_RPT1   = 16'h5250;
  localparam logic [15:0] HDR_POS_RPT2   = 16'h5257;
  localparam logic [15:0] HDR_EXT_INPUT  = 16'h494e;
  localparam logic [15:0] HDR_ERROR      = 16'h5858;
  // apb register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_ERRCNT = 12'h008;
  localparam int          CTRL_EXT_BIT = 8;
  // extended word 1 field positions
  localparam int EXT_NUM_LSB  = 0;
  localparam int EXT_TYPE_LSB = 4;
  localparam int EXT_MODE_LSB = 6;
  // status word: device two field base
  localparam int STAT_DEV2_LSB = 8;
  // modes and device types
  localparam logic [1:0] MODE_AUTO_TRK = 2'h0;
  localparam logic [1:0] MODE_AUTO     = 2'h1;
  localparam logic [1:0] MODE_REQUEST  = 2'h2;
  localparam logic [1:0] TYPE_KEYBD    = 2'h0;
  localparam logic [1:0] TYPE_FKEYS    = 2'h1;
  localparam logic [1:0] TYPE_TRKBALL  = 2'h2;
  localparam logic [1:0] TYPE_TABLET   = 2'h3;
  // reset values
  localparam logic [1:0] MODE_RST   = 2'h2;
  localparam logic [1:0] IRQ_EN_RST = 2'h3;
  typedef enum {ST_HDR, ST_BODY, ST_EXEC, ST_SEND} msg_state_e;
endpackage : ped_msg_pkg

// ===== hdl/ped_channel.sv
`timescale 1ns/10ps
module ped_channel (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        set_mode,
  input  wire logic [1:0]  mode_in,
  input  wire logic        set_type,
  input  wire logic        tablet_in,
  input  wire logic        pen_press,
  input  wire logic        dev_irq,
  input  wire logic        irq_en,
  input  wire logic [7:0]  rel_x,
  input  wire logic [7:0]  rel_y,
  input  wire logic [11:0] abs_x,
  input  wire logic [11:0] abs_y,
  input  wire logic        clear,
  output logic [1:0]       mode,
  output logic             tablet,
  output logic             pend,
  output logic [15:0]      rep_x,
  output logic [15:0]      rep_y,
  output logic [15:0]      pos_x,
  output logic [15:0]      pos_y
);
  logic ev;
  // report triggers; request/tracking modes never fire here
  assign ev = (mode == ped_msg_pkg::MODE_AUTO_TRK && tablet && pen_press)
    || (mode == ped_msg_pkg::MODE_AUTO && irq_en && dev_irq);

  // configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode   <= ped_msg_pkg::MODE_RST;
      tablet <= 1'b0;
    end else begin
      if (set_mode) mode <= mode_in;
      if (set_type) tablet <= tablet_in;
    end
  end

  // pending flag: a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend <= 1'b0;
    else if (ev) pend <= 1'b1;
    else if (clear) pend <= 1'b0;
  end

  // report data, latched with the event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_x <= 16'h0000;
      rep_y <= 16'h0000;
    end else if (ev && mode == ped_msg_pkg::MODE_AUTO) begin
      rep_x <= {{8{rel_x[7]}}, rel_x};
      rep_y <= {{8{rel_y[7]}}, rel_y};
    end else if (ev) begin
      rep_x <= {{4{abs_x[11]}}, abs_x};
      rep_y <= {{4{abs_y[11]}}, abs_y};
    end
  end

  // tracked absolute position for host requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_x <= 16'h0000;
      pos_y <= 16'h0000;
    end else begin
      pos_x <= {{4{abs_x[11]}}, abs_x};
      pos_y <= {{4{abs_y[11]}}, abs_y};
    end
  end

  no_irq_rpt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode[1] && !pend && !set_mode) |=> !pend)
    else $error("report started in request or tracking mode");
  rel_sext_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev && mode == ped_msg_pkg::MODE_AUTO) |=> (rep_x == {{8{$past(rel_x[7])}}, $past(rel_x)}))
    else $error("relative x not sign extended from bit 7");
  abs_sext_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (pos_y == {{4{$past(abs_y[11])}}, $past(abs_y)}))
    else $error("absolute y not sign extended from bit 11");
endmodule : ped_channel

// ===== hdl/ped_msg_handler.sv
`timescale 1ns/10ps
// Overview of operation
// - status query answered with status reply
// - device one bits 0-2, two 8-10
// - type bit and two mode bits encoding
// - position request answered by position report
// - request in mode 0/1 gives error
// - report headers differ per device
// - modes 0/1 report unprompted, 2/3 on request
// - report word one: mode, zeros above
// - mode 0 tablet pen press sends absolute report
// - mode 1 interrupt sends relative report, gated
// - relative values sign-extended from bit 7
// - absolute values sign-extended from bit 11
// - modes 2/3 ignore device interrupts
// - system init enables pointing devices
// - extended control needs enter message first
// - extended word one fields, number is n-1
// - extended device type codes 0 to 3
// - extended trackball setup, modes 1-3
// - extended tablet setup, modes 0,2,3
// - extended request: scratchpad, lights, position; a keyboard scratchpad request is taken and ignored
// - extended input message reports position
// - keyboard scratchpad setup carries type 0
// - status query recognised by its header
module ped_msg_handler #(
  parameter int NUM_PEDS = 2
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      in_valid,
  output logic                           in_ready,
  input  wire logic [15:0]               in_word,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [15:0]                    out_word,
  output logic                           out_last,
  input  wire logic                      sys_init,
  input  wire logic [NUM_PEDS-1:0]       pen_press,
  input  wire logic [NUM_PEDS-1:0]       dev_irq,
  input  wire logic [NUM_PEDS-1:0][7:0]  rel_x,
  input  wire logic [NUM_PEDS-1:0][7:0]  rel_y,
  input  wire logic [NUM_PEDS-1:0][11:0] abs_x,
  input  wire logic [NUM_PEDS-1:0][11:0] abs_y,
  output logic [15:0]                    key_lights,
  output logic [15:0]                    matrix_lights
);
  ped_msg_pkg::msg_state_e state;
  logic [15:0]                hdr;
  logic [15:0]                body [0:2];
  logic [1:0]                 body_idx;
  logic [1:0]                 need;
  logic [15:0]                ob [0:3];
  logic [2:0]                 out_cnt;
  logic [1:0]                 out_idx;
  logic                       ext_mode;
  logic [NUM_PEDS-1:0]        irq_en;
  logic [7:0]                 err_cnt;
  logic [NUM_PEDS-1:0][1:0]   mode;
  logic [NUM_PEDS-1:0]        tablet;
  logic [NUM_PEDS-1:0]        pend;
  logic [NUM_PEDS-1:0]        clear;
  logic [NUM_PEDS-1:0][15:0]  rep_x;
  logic [NUM_PEDS-1:0][15:0]  rep_y;
  logic [NUM_PEDS-1:0][15:0]  pos_x;
  logic [NUM_PEDS-1:0][15:0]  pos_y;
  logic [NUM_PEDS-1:0]        set_mode;
  logic [NUM_PEDS-1:0]        set_type;
  logic [1:0]                 new_mode;
  logic                       new_tab;
  logic [15:0]                stat_word;
  logic                       apb_wr;
  logic [1:0]                 x_mode;
  logic [1:0]                 x_type;
  logic [2:0]                 x_num;
  logic                       x_hit;
  logic [0:0]                 x_sel;
  logic                       auto_go;
  logic [0:0]                 auto_sel;
  logic                       in_take;
  logic                       out_take;

  // extended word one fields; number is already index n-1
  assign x_mode = body[0][ped_msg_pkg::EXT_MODE_LSB +: 2];
  assign x_type = body[0][ped_msg_pkg::EXT_TYPE_LSB +: 2];
  assign x_num  = body[0][ped_msg_pkg::EXT_NUM_LSB +: 3];
  assign x_hit  = ({29'h0, x_num} < NUM_PEDS);
  assign x_sel  = x_num[0:0];

  // status word: type in bit 0, mode in bits 2:1
  assign stat_word = {5'h00, mode[1], tablet[1],
                      5'h00, mode[0], tablet[0]};

  // unprompted reports go out only between host messages
  assign auto_go  = (state == ped_msg_pkg::ST_HDR) && (|pend);
  assign auto_sel = pend[0] ? 1'b0 : 1'b1;

  // host words are refused while a reply is built or sent
  assign in_ready = ((state == ped_msg_pkg::ST_HDR) && !(|pend))
                 || (state == ped_msg_pkg::ST_BODY);
  assign in_take  = in_valid && in_ready;
  assign out_valid = (state == ped_msg_pkg::ST_SEND) && (out_cnt != 3'h0);
  assign out_word  = ob[out_idx];
  assign out_last  = out_valid && ({1'b0, out_idx} == out_cnt - 3'h1);
  assign out_take  = out_valid && out_ready;

  // per-device state, pending reports and position capture
  genvar g;
  generate
    for (g = 0; g < NUM_PEDS; g++) begin : g_ped
      assign clear[g] = auto_go && (auto_sel == 1'(g));
      ped_channel u_chan (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_mode  (set_mode[g]),
        .mode_in   (new_mode),
        .set_type  (set_type[g]),
        .tablet_in (new_tab),
        .pen_press (pen_press[g]),
        .dev_irq   (dev_irq[g]),
        .irq_en    (irq_en[g]),
        .rel_x     (rel_x[g]),
        .rel_y     (rel_y[g]),
        .abs_x     (abs_x[g]),
        .abs_y     (abs_y[g]),
        .clear     (clear[g]),
        .mode      (mode[g]),
        .tablet    (tablet[g]),
        .pend      (pend[g]),
        .rep_x     (rep_x[g]),
        .rep_y     (rep_y[g]),
        .pos_x     (pos_x[g]),
        .pos_y     (pos_y[g])
      );
    end
  endgenerate

  // configuration writes decoded from a complete message
  always_comb begin
    set_mode = '0;
    set_type = '0;
    new_mode = body[0][1:0];
    new_tab  = 1'b0;
    if (state == ped_msg_pkg::ST_EXEC) begin
      case (hdr)
        ped_msg_pkg::HDR_PSETUP1:   set_mode[0] = 1'b1;
        ped_msg_pkg::HDR_PSETUP2:   set_mode[1] = 1'b1;
        ped_msg_pkg::HDR_TAB_ASSN1: begin
          set_type[0] = 1'b1;
          new_tab     = 1'b1;
        end
        ped_msg_pkg::HDR_TAB_ASSN2: begin
          set_type[1] = 1'b1;
          new_tab     = 1'b1;
        end
        ped_msg_pkg::HDR_EXT_SETUP: begin
          new_mode = x_mode;
          new_tab  = (x_type == ped_msg_pkg::TYPE_TABLET);
          if (ext_mode && x_hit && ((x_type == ped_msg_pkg::TYPE_TRKBALL
              && x_mode != ped_msg_pkg::MODE_AUTO_TRK)
              || (x_type == ped_msg_pkg::TYPE_TABLET
              && x_mode != ped_msg_pkg::MODE_AUTO))) begin
            set_mode[x_sel] = 1'b1;
            set_type[x_sel] = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // message sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ped_msg_pkg::ST_HDR;
      hdr      <= 16'h0000;
      need     <= 2'h0;
      body_idx <= 2'h0;
      body[0]  <= 16'h0000;
      body[1]  <= 16'h0000;
      body[2]  <= 16'h0000;
    end else begin
      case (state)
        ped_msg_pkg::ST_HDR: begin
          if (auto_go) begin
            state <= ped_msg_pkg::ST_SEND;
          end else if (in_take) begin
            hdr      <= in_word;
            body_idx <= 2'h0;
            case (in_word)
              ped_msg_pkg::HDR_PSETUP1,
              ped_msg_pkg::HDR_PSETUP2: begin
                need  <= 2'h2;
                state <= ped_msg_pkg::ST_BODY;
              end
              ped_msg_pkg::HDR_EXT_SETUP: begin
                need  <= 2'h3;
                state <= ped_msg_pkg::ST_BODY;
              end
              ped_msg_pkg::HDR_IRQ_CTL,
              ped_msg_pkg::HDR_EXT_REQ: begin
                need  <= 2'h1;
                state <= ped_msg_pkg::ST_BODY;
              end
              default: state <= ped_msg_pkg::ST_EXEC;
            endcase
          end
        end
        ped_msg_pkg::ST_BODY: begin
          if (in_take) begin
            body[body_idx] <= in_word;
            body_idx       <= body_idx + 2'h1;
            // light-key request carries two mask words more
            if (hdr == ped_msg_pkg::HDR_EXT_REQ && body_idx == 2'h0
                && in_word[ped_msg_pkg::EXT_TYPE_LSB +: 2] == ped_msg_pkg::TYPE_FKEYS) begin
              need <= 2'h3;
            end else if (body_idx + 2'h1 == need) begin
              state <= ped_msg_pkg::ST_EXEC;
            end
          end
        end
        ped_msg_pkg::ST_EXEC: begin
          state <= ped_msg_pkg::ST_SEND; // reply length not known until send
        end
        ped_msg_pkg::ST_SEND: begin
          if (out_cnt == 3'h0 || (out_take && out_last)) state <= ped_msg_pkg::ST_HDR;
        end
        default: state <= ped_msg_pkg::ST_HDR;
      endcase
    end
  end

  // reply builder: out_cnt is only valid one cycle after exec
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cnt <= 3'h0;
      out_idx <= 2'h0;
      ob[0]   <= 16'h0000;
      ob[1]   <= 16'h0000;
      ob[2]   <= 16'h0000;
      ob[3]   <= 16'h0000;
    end else if (auto_go) begin
      ob[0]   <= auto_sel[0] ? ped_msg_pkg::HDR_POS_RPT2
                             : ped_msg_pkg::HDR_POS_RPT1;
      ob[1]   <= {14'h0000, mode[auto_sel]};
      ob[2]   <= rep_x[auto_sel];
      ob[3]   <= rep_y[auto_sel];
      out_cnt <= 3'h4;
      out_idx <= 2'h0;
    end else if (state == ped_msg_pkg::ST_SEND) begin
      if (out_take) out_idx <= out_idx + 2'h1;
    end else if (state != ped_msg_pkg::ST_EXEC) begin
      out_cnt <= 3'h0;
      out_idx <= 2'h0;
    end else begin
      out_idx <= 2'h0;
      out_cnt <= 3'h0;
      case (hdr)
        ped_msg_pkg::HDR_STAT_QUERY: begin
          ob[0]   <= ped_msg_pkg::HDR_STAT_REPLY;
          ob[1]   <= stat_word;
          out_cnt <= 3'h2;
        end
        ped_msg_pkg::HDR_POS_REQ1,
        ped_msg_pkg::HDR_POS_REQ2: begin
          if (mode[hdr[2]][1]) begin
            ob[0]   <= hdr[2] ? ped_msg_pkg::HDR_POS_RPT2
                              : ped_msg_pkg::HDR_POS_RPT1;
            ob[1]   <= {14'h0000, mode[hdr[2]]};
            ob[2]   <= pos_x[hdr[2]];
            ob[3]   <= pos_y[hdr[2]];
            out_cnt <= 3'h4;
          end else begin
            ob[0]   <= ped_msg_pkg::HDR_ERROR;
            out_cnt <= 3'h1;
          end
        end
        ped_msg_pkg::HDR_EXT_SETUP: begin
          if (!ext_mode) begin
            ob[0]   <= ped_msg_pkg::HDR_ERROR;
            out_cnt <= 3'h1;
          end
        end
        ped_msg_pkg::HDR_EXT_REQ: begin
          if (!ext_mode) begin
            ob[0]   <= ped_msg_pkg::HDR_ERROR;
            out_cnt <= 3'h1;
          end else if (x_type[1]) begin
            if (x_hit && mode[x_sel][1] && x_mode == mode[x_sel]
                && tablet[x_sel] == x_type[0]) begin
              ob[0]   <= ped_msg_pkg::HDR_EXT_INPUT;
              ob[1]   <= {8'h00, x_mode, x_type, 1'b0, x_num};
              ob[2]   <= pos_x[x_sel];
              ob[3]   <= pos_y[x_sel];
              out_cnt <= 3'h4;
            end else begin
              ob[0]   <= ped_msg_pkg::HDR_ERROR;
              out_cnt <= 3'h1;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // key light masks from the extended request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_lights    <= 16'h0000;
      matrix_lights <= 16'h0000;
    end else if (state == ped_msg_pkg::ST_EXEC && ext_mode
                 && hdr == ped_msg_pkg::HDR_EXT_REQ
                 && x_type == ped_msg_pkg::TYPE_FKEYS) begin
      key_lights    <= body[1];
      matrix_lights <= body[2];
    end
  end

  // extended mode and interrupt enables; system init wins last
  assign apb_wr = psel && penable && pwrite && (paddr == ped_msg_pkg::ADDR_CTRL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode <= 1'b0;
      irq_en   <= {NUM_PEDS{1'b1}};
    end else begin
      if (apb_wr) irq_en <= pwdata[NUM_PEDS-1:0];
      if (state == ped_msg_pkg::ST_EXEC) begin
        if (hdr == ped_msg_pkg::HDR_EXT_ENTER) ext_mode <= 1'b1;
        if (hdr == ped_msg_pkg::HDR_IRQ_CTL) irq_en <= body[0][NUM_PEDS-1:0];
      end
      if (sys_init) begin
        irq_en   <= {NUM_PEDS{1'b1}};
        ext_mode <= 1'b0;
      end
    end
  end

  // error replies counted for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) err_cnt <= 8'h00;
    else if (out_take && out_idx == 2'h0 && out_word == ped_msg_pkg::HDR_ERROR)
      err_cnt <= err_cnt + 8'h01;
  end

  // apb slave: zero wait states, error on unmapped address
  assign pready = 1'b1;
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      ped_msg_pkg::ADDR_CTRL:
        prdata = {23'h0, ext_mode, {(8 - NUM_PEDS){1'b0}}, irq_en};
      ped_msg_pkg::ADDR_STATUS: prdata = {16'h0000, stat_word};
      ped_msg_pkg::ADDR_ERRCNT: prdata = {24'h0, err_cnt};
      default: pslverr = psel && penable;
    endcase
  end

  stat_reply_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ped_msg_pkg::ST_EXEC && hdr == ped_msg_pkg::HDR_STAT_QUERY)
    |=> out_valid && out_word == ped_msg_pkg::HDR_STAT_REPLY)
    else $error("status query not answered with status reply");
  pos_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ped_msg_pkg::ST_EXEC && hdr == ped_msg_pkg::HDR_POS_REQ1 && !mode[0][1])
    |=> out_word == ped_msg_pkg::HDR_ERROR && out_last)
    else $error("request in automatic mode not refused");
  pos_hdr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ped_msg_pkg::ST_EXEC && hdr == ped_msg_pkg::HDR_POS_REQ2 && mode[1][1])
    |=> out_word == ped_msg_pkg::HDR_POS_RPT2 ##1 out_cnt == 3'h4)
    else $error("device two report header wrong");
  rpt_word1_a: assert property (@(posedge pclk) disable iff (!presetn)
    (out_valid && out_idx == 2'h1 && (ob[0] == ped_msg_pkg::HDR_POS_RPT1
     || ob[0] == ped_msg_pkg::HDR_POS_RPT2)) |-> out_word[15:2] == 14'h0000)
    else $error("report word one upper bits not zero");
  ext_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ped_msg_pkg::ST_EXEC && hdr == ped_msg_pkg::HDR_EXT_SETUP && !ext_mode)
    |-> !(|set_mode) ##1 out_word == ped_msg_pkg::HDR_ERROR)
    else $error("extended setup accepted outside extended mode");
  in_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ped_msg_pkg::ST_EXEC || out_valid) |-> !in_ready)
    else $error("host word taken while reply pending");
  sys_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    sys_init |=> (&irq_en) && !ext_mode)
    else $error("system init did not enable devices");
endmodule : ped_msg_handler

// ===== sim/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic   pclk,
  input  wire logic   presetn,
  output logic        in_valid,
  input  wire logic   in_ready,
  output logic [15:0] in_word,
  output logic        out_ready,
  output logic        timed_out
);
  logic [1:0] pace;
  initial begin
    in_valid = 1'b0;
    in_word = 16'h0000;
    timed_out = 1'b0;
  end
  // reply sink stalls one cycle in four, so prompt and slow takes both occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      out_ready <= (pace != 2'h3);
    end
  end
  // whole message, word held until taken, one message at a time
  task automatic msg(input logic [15:0] w [4], input int cnt);
    int n;
    for (int i = 0; i < cnt; i++) begin
      in_valid <= 1'b1;
      in_word <= w[i];
      n = 0;
      @(posedge pclk);
      while (in_ready !== 1'b1 && n < 200) begin
        n++;
        @(posedge pclk);
      end
      if (n == 200) timed_out = 1'b1;
    end
    in_valid <= 1'b0;
    in_word <= ~w[cnt-1]; // released word never shows the stale value
    @(posedge pclk);
  endtask : msg
endmodule : host_model

// ===== sim/pointer_device_message_handler_bench.sv
`timescale 1ns/10ps
module pointer_device_message_handler_bench;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, sys_init;
  logic             in_valid, in_ready, out_valid, out_ready, out_last, timed_out;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, seed;
  logic [15:0]      in_word, out_word, key_lights, matrix_lights;
  logic [1:0]       pen_press, dev_irq;
  logic [1:0][7:0]  rel_x, rel_y;
  logic [1:0][11:0] abs_x, abs_y;
  logic [16:0]      expq[$];
  int               errors, comparisons;
  ped_msg_handler dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_ready, .in_word, .out_valid, .out_ready, .out_word, .out_last, .sys_init, .pen_press,
    .dev_irq, .rel_x, .rel_y, .abs_x, .abs_y, .key_lights, .matrix_lights);
  host_model host (.pclk, .presetn, .in_valid, .in_ready, .in_word, .out_ready, .timed_out);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [15:0] sx12(input logic [11:0] v);
    return {{4{v[11]}}, v};
  endfunction : sx12
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] sx8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction : sx8
  task automatic fail(input string m);
    errors++;
    $display("CHECK FAILED %0t: %s", $time, m);
  endtask : fail
  task automatic check_word(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("reply %h expected %h", got, exp));
  endtask : check_word
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("register %h expected %h", got, exp));
  endtask : check_reg
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // fresh positions from the lfsr, settled one edge before use
  task automatic roll;
    repeat (16) seed = lfsr(seed);
    abs_x <= {seed[27:16], seed[11:0]};
    abs_y <= {seed[11:0], seed[31:20]};
    rel_x <= seed[15:0];
    rel_y <= seed[31:16];
    @(posedge pclk);
  endtask : roll
  task automatic exp4(input logic [15:0] h, input logic [15:0] a, input logic [15:0] x, input logic [15:0] y);
    expq.push_back({1'b0, h});
    expq.push_back({1'b0, a});
    expq.push_back({1'b0, x});
    expq.push_back({1'b1, y});
  endtask : exp4
  task automatic pulse(input logic [1:0] irq, input logic [1:0] pen);
    dev_irq <= irq;
    pen_press <= pen;
    @(posedge pclk);
    dev_irq <= 2'b00;
    pen_press <= 2'b00;
    @(posedge pclk);
  endtask : pulse
  // bounded wait for all noted replies and a ready input
  task automatic drain;
    int n;
    n = 0;
    while ((expq.size() != 0 || in_ready !== 1'b1) && n < 500) begin
      n++;
      @(posedge pclk);
    end
    if (n == 500 || timed_out === 1'b1) begin
      fail("reply or handshake timeout");
      report_and_stop;
    end
    repeat (4) @(posedge pclk);
  endtask : drain
  task automatic status(input logic [15:0] w);
    expq.push_back({1'b0, ped_msg_pkg::HDR_STAT_REPLY});
    expq.push_back({1'b1, w});
    host.msg('{ped_msg_pkg::HDR_STAT_QUERY, 16'h0, 16'h0, 16'h0}, 1);
    drain;
  endtask : status
  // zero wait states are not assumed; the request holds until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp,
                     input logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) fail("apb ready timeout");
    if (!wr) check_reg(prdata, exp);
    check_reg({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // reply watcher: oldest note against each word taken
  always @(posedge pclk) begin
    if (presetn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (expq.size() == 0) fail("unexpected reply word");
      else check_word({out_last, out_word}, expq.pop_front());
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, sys_init} = 5'h00;
    {paddr, pwdata, pen_press, dev_irq, rel_x, rel_y, abs_x, abs_y} = '0;
    {errors, comparisons} = '0;
    seed = 32'h0001_0db5;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    roll;
    status(16'h0404);
    for (int i = 0; i < 4; i++) begin
      exp4(i[0] ? ped_msg_pkg::HDR_POS_RPT2 : ped_msg_pkg::HDR_POS_RPT1, 16'h0002, sx12(abs_x[i[0]]),
           sx12(abs_y[i[0]]));
      host.msg('{i[0] ? ped_msg_pkg::HDR_POS_REQ2 : ped_msg_pkg::HDR_POS_REQ1, 16'h0, 16'h0, 16'h0}, 1);
      drain;
      roll;
    end
    pulse(2'b11, 2'b00);
    drain;
    host.msg('{ped_msg_pkg::HDR_PSETUP1, 16'h0001, 16'h0000, 16'h0}, 3);
    exp4(ped_msg_pkg::HDR_POS_RPT1, 16'h0001, sx8(rel_x[0]), sx8(rel_y[0]));
    pulse(2'b01, 2'b00);
    drain;
    expq.push_back({1'b1, ped_msg_pkg::HDR_ERROR});
    host.msg('{ped_msg_pkg::HDR_POS_REQ1, 16'h0, 16'h0, 16'h0}, 1);
    drain;
    apb(1'b1, ped_msg_pkg::ADDR_CTRL, 32'h0, 32'h0, 1'b0);
    pulse(2'b01, 2'b00);
    drain;
    apb(1'b0, ped_msg_pkg::ADDR_STATUS, 32'h0, 32'h0402, 1'b0);
    apb(1'b0, ped_msg_pkg::ADDR_ERRCNT, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
    sys_init <= 1'b1;
    @(posedge pclk);
    sys_init <= 1'b0;
    @(posedge pclk);
    apb(1'b0, ped_msg_pkg::ADDR_CTRL, 32'h0, 32'h3, 1'b0);
    host.msg('{ped_msg_pkg::HDR_TAB_ASSN1, 16'h0, 16'h0, 16'h0}, 1);
    host.msg('{ped_msg_pkg::HDR_PSETUP1, 16'h0000, 16'h0100, 16'h0}, 3);
    exp4(ped_msg_pkg::HDR_POS_RPT1, 16'h0000, sx12(abs_x[0]), sx12(abs_y[0]));
    pulse(2'b00, 2'b01);
    drain;
    status(16'h0401);
    expq.push_back({1'b1, ped_msg_pkg::HDR_ERROR});
    host.msg('{ped_msg_pkg::HDR_EXT_SETUP, 16'h00b1, 16'h0, 16'h0}, 4);
    drain;
    host.msg('{ped_msg_pkg::HDR_EXT_ENTER, 16'h0, 16'h0, 16'h0}, 1);
    apb(1'b0, ped_msg_pkg::ADDR_CTRL, 32'h0, 32'h103, 1'b0);
    exp4(ped_msg_pkg::HDR_EXT_INPUT, 16'h00a1, sx12(abs_x[1]), sx12(abs_y[1]));
    host.msg('{ped_msg_pkg::HDR_EXT_REQ, 16'h00a1, 16'h0, 16'h0}, 2);
    drain;
    host.msg('{ped_msg_pkg::HDR_EXT_REQ, 16'h0010, seed[15:0], seed[31:16]}, 4);
    drain;
    check_reg({matrix_lights, key_lights}, seed);
    host.msg('{ped_msg_pkg::HDR_EXT_SETUP, 16'h0021, 16'h0, 16'h0}, 4);
    host.msg('{ped_msg_pkg::HDR_EXT_SETUP, 16'h00b1, 16'h0, 16'h0}, 4);
    status(16'h0501);
    report_and_stop;
  end
endmodule : pointer_device_message_handler_bench
